// *** core/pms_defs.svh ***
// Timing counts and field positions for the power mode sequencer.
// Assumes inclusion by bare name from both ends of the link.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
// Core-halt wake, wake source to first instruction, in clocks.
`define PMS_HALT_WAKE_MIN 4
`define PMS_HALT_WAKE_MAX 5
// Clocks from wake detect to resume for each exit path.
`define PMS_HALT_WAKE_CLKS 4
`define PMS_STOP_FAST_CLKS 16
`define PMS_STOP_SLOW_CLKS 64
// Fast-wake clock source select values.
`define PMS_FW_SRC_LFOSC 1'b0
`define PMS_FW_SRC_RTC 1'b1
// Retention wake source bit positions.
`define PMS_RW_LPTIMER 0
`define PMS_RW_RTC_ALARM 1
`define PMS_RW_RTC_OSCFAIL 2
`define PMS_RW_COMPARATOR_ZERO 3
`define PMS_RW_CAPCTR 4
`define PMS_RW_LCD_VBAT 5
`define PMS_RW_UART 6
`define PMS_RW_CP_FAIL 7
`define PMS_RW_PINWAKE 8
`define PMS_RW_COUNT 9
// Retention reset source bit positions.
`define PMS_RR_PIN 0
`define PMS_RR_VBAT_MON 1
`define PMS_RR_COMPARATOR_ZERO 2
`define PMS_RR_COMPARATOR_ONE 3
`define PMS_RR_CP_FAIL 4
`define PMS_RR_RTC_OSCFAIL 5
`define PMS_RR_PMU_WAKE 6
`define PMS_RR_COUNT 7
`endif

// *** core/pms_pkg.sv ***
// Types shared by both ends of the power mode sequencer link.
// Assumes the defs header for counts and positions.
package pms_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    PMS_ST_RUN = 6'h01,
    PMS_ST_HALT = 6'h02,
    PMS_ST_STOP = 6'h04,
    PMS_ST_RET = 6'h08,
    PMS_ST_WAKE = 6'h10,
    PMS_ST_RST = 6'h20
  } pms_state_t;
  // Reported power mode, one-hot.
  typedef enum logic [7:0] {
    PMS_MODE_FLASH_RUN = 8'h01,
    PMS_MODE_FLASH_RUN_SLOW = 8'h02,
    PMS_MODE_RAM_RUN = 8'h04,
    PMS_MODE_RAM_RUN_SLOW = 8'h08,
    PMS_MODE_CORE_HALT = 8'h10,
    PMS_MODE_CORE_HALT_SLOW = 8'h20,
    PMS_MODE_CLOCK_STOP = 8'h40,
    PMS_MODE_RETENTION = 8'h80
  } pms_mode_t;
  // Core end states, one-hot.
  typedef enum logic [3:0] {
    PMS_CS_EXEC = 4'h1,
    PMS_CS_DRAIN = 4'h2,
    PMS_CS_SLEEP = 4'h4,
    PMS_CS_POWOFF = 4'h8
  } pms_core_state_t;
endpackage

// *** core/pms_link_if.sv ***
// Link between the processor core end and the power mode sequencer.
// Assumes one shared clock; the testbench connects both modports.
`timescale 1ns/1ps
interface pms_link_if;
  // Core to sequencer.
  logic wait_req;
  logic deep_sleep_flag;
  logic wake_recognized;
  // Sequencer to core.
  logic core_clk_en;
  logic resume;
  logic core_reset;
  modport core_end (
    output wait_req,
    output deep_sleep_flag,
    output wake_recognized,
    input core_clk_en,
    input resume,
    input core_reset
  );
  modport seq_end (
    input wait_req,
    input deep_sleep_flag,
    input wake_recognized,
    output core_clk_en,
    output resume,
    output core_reset
  );
endinterface

// *** core/pms_sequencer.sv ***
// Power mode sequencer: run, core-halt, clock-stop and retention modes.
// Assumes the core end on the link and power management inputs on one clock.
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int STOP_WAKES = 8,
  parameter int RAM_BLOCKS = 4
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Core link.
  pms_link_if.seq_end link,
  // Run configuration.
  input wire logic run_from_ram,
  input wire logic slow_clock_sel,
  input wire logic deep_mode_select,
  // Clock-stop configuration and sources.
  input wire logic fast_wake_en,
  input wire logic fast_wake_src,
  input wire logic [STOP_WAKES-1:0] stop_wake_mask,
  input wire logic [STOP_WAKES-1:0] stop_wake_src,
  // Retention configuration and sources.
  input wire logic charge_pump_sel,
  input wire logic [RAM_BLOCKS-1:0] ram_retain_sel,
  input wire logic [`PMS_RW_COUNT-1:0] ret_wake_mask,
  input wire logic [`PMS_RW_COUNT-1:0] ret_wake_src,
  input wire logic [`PMS_RR_COUNT-1:0] ret_reset_mask,
  input wire logic [`PMS_RR_COUNT-1:0] ret_reset_src,
  // Clock controls.
  output logic periph_clk_en,
  output logic clk_slow,
  output logic lf_osc_keep,
  output logic rtc_clk_keep,
  // Power controls.
  output logic core_pwr_en,
  output logic periph_pwr_en,
  output logic regulator_en,
  output logic charge_pump_en,
  output logic [RAM_BLOCKS-1:0] ram_pwr_en,
  output logic lp_domain_en,
  // Status.
  output pms_mode_t power_mode,
  output logic sys_reset_req
);

  localparam logic [7:0] HALT_LOAD = 8'(`PMS_HALT_WAKE_CLKS - 1);
  localparam logic [7:0] FAST_LOAD = 8'(`PMS_STOP_FAST_CLKS - 1);
  localparam logic [7:0] SLOW_LOAD = 8'(`PMS_STOP_SLOW_CLKS - 1);

  pms_state_t state_r;
  pms_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic resume_r;
  logic rst_req_r;
  pms_mode_t mode_r;
  pms_mode_t mode_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Entry and exit decode.

  // Target of a wait instruction follows the deep flag and the select bit.
  wire go_halt = link.wait_req & ~link.deep_sleep_flag;
  wire go_stop = link.wait_req & link.deep_sleep_flag & ~deep_mode_select;
  wire go_ret = link.wait_req & link.deep_sleep_flag & deep_mode_select;
  // Core-halt wakes on any interrupt the core has recognized.
  wire halt_wake = link.wake_recognized;
  // Only enabled sources may end clock-stop.
  wire stop_wake = |(stop_wake_src & stop_wake_mask);
  wire ret_wake = |(ret_wake_src & ret_wake_mask);
  // A wake event in retention becomes a reset only if that path is allowed.
  wire ret_exit = (|(ret_reset_src & ret_reset_mask))
    | (ret_wake & ret_reset_mask[`PMS_RR_PMU_WAKE]);
  wire in_ret = state_r == PMS_ST_RET;
  wire in_stop = state_r == PMS_ST_STOP;
  wire fw_keep = in_stop & fast_wake_en;

  //////////////////////////////////////////////////////////////////////////////
  // State machine.

  // Wake counts load one short so the registered resume lands on the final clock.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      PMS_ST_RUN:
      begin
        if (go_halt)
          state_nxt = PMS_ST_HALT;
        else if (go_stop)
          state_nxt = PMS_ST_STOP;
        else if (go_ret)
          state_nxt = PMS_ST_RET;
      end
      PMS_ST_HALT:
      begin
        if (halt_wake)
        begin
          state_nxt = PMS_ST_WAKE;
          cnt_nxt = HALT_LOAD;
        end
      end
      PMS_ST_STOP:
      begin
        if (stop_wake)
        begin
          state_nxt = PMS_ST_WAKE;
          cnt_nxt = fast_wake_en ? FAST_LOAD : SLOW_LOAD;
        end
      end
      PMS_ST_RET:
      begin
        if (ret_exit)
          state_nxt = PMS_ST_RST;
      end
      PMS_ST_WAKE:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
          state_nxt = PMS_ST_RUN;
      end
      PMS_ST_RST:
      begin
        state_nxt = PMS_ST_RUN;
      end
      default:
      begin
        state_nxt = PMS_ST_RUN;
        cnt_nxt = 8'h00;
      end
    endcase
  end

  // Reported mode follows the state and the run configuration.
  always_comb
  begin
    mode_nxt = PMS_MODE_FLASH_RUN;
    case (state_nxt)
      PMS_ST_HALT:
        mode_nxt = slow_clock_sel ? PMS_MODE_CORE_HALT_SLOW : PMS_MODE_CORE_HALT;
      PMS_ST_STOP:
        mode_nxt = PMS_MODE_CLOCK_STOP;
      PMS_ST_RET:
        mode_nxt = PMS_MODE_RETENTION;
      default:
      begin
        if (run_from_ram)
          mode_nxt = slow_clock_sel ? PMS_MODE_RAM_RUN_SLOW : PMS_MODE_RAM_RUN;
        else
          mode_nxt = slow_clock_sel ? PMS_MODE_FLASH_RUN_SLOW : PMS_MODE_FLASH_RUN;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= PMS_ST_RUN;
      cnt_r <= 8'h00;
      resume_r <= 1'b0;
      rst_req_r <= 1'b0;
      mode_r <= PMS_MODE_FLASH_RUN;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      resume_r <= (state_r == PMS_ST_WAKE) && (cnt_r == 8'h01);
      rst_req_r <= in_ret & ret_exit;
      mode_r <= mode_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock and power outputs.

  // The core clock runs only in run; halt and stop keep it off.
  assign link.core_clk_en = state_r == PMS_ST_RUN;
  assign link.resume = resume_r;
  assign link.core_reset = rst_req_r;
  // Peripherals restart during the wake count so they are ready at resume.
  assign periph_clk_en = (state_r == PMS_ST_RUN) | (state_r == PMS_ST_HALT)
    | (state_r == PMS_ST_WAKE);
  assign clk_slow = slow_clock_sel;
  // The oscillator and calendar clocks are left running outside clock-stop.
  assign lf_osc_keep = ~in_stop | (fw_keep & (fast_wake_src == `PMS_FW_SRC_LFOSC));
  assign rtc_clk_keep = ~in_stop | (fw_keep & (fast_wake_src == `PMS_FW_SRC_RTC));
  // Registers keep state by staying unreset; only supplies drop.
  assign core_pwr_en = ~in_ret;
  assign periph_pwr_en = ~in_ret;
  assign regulator_en = ~in_ret;
  assign charge_pump_en = in_ret & charge_pump_sel;
  assign ram_pwr_en = in_ret ? ram_retain_sel : {RAM_BLOCKS{1'b1}};
  // Timer, calendar, serial port, pin wake, counter and display stay supplied.
  assign lp_domain_en = 1'b1;
  assign power_mode = mode_r;
  assign sys_reset_req = rst_req_r;

endmodule

// *** core/pms_core_end.sv ***
// Processor core end of the power mode link: wait issue, wake recognition.
// Assumes software drives the user-side requests on the same clock.
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_core_end
  import pms_pkg::*;
#(
  parameter int IRQS = 8,
  parameter int PRIO_W = 3
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Sequencer link.
  pms_link_if.core_end link,
  // Software requests.
  input wire logic wfi_req,
  input wire logic wfe_req,
  input wire logic deep_sleep_set,
  input wire logic fast_wake_want,
  input wire logic low_power_oscillator_clocking,
  // Bus and DMA status.
  input wire logic bus_busy,
  input wire logic dma_active,
  // Interrupts and events.
  input wire logic [IRQS-1:0] irq_pend,
  input wire logic [IRQS*PRIO_W-1:0] irq_prio,
  input wire logic in_handler,
  input wire logic [PRIO_W-1:0] cur_prio,
  input wire logic event_in,
  // Status.
  output logic core_running,
  output logic resumed,
  output logic restarted
);

  pms_core_state_t state_r;
  pms_core_state_t state_nxt;
  logic is_wfe_r;
  logic event_r;
  logic deep_r;
  logic resumed_r;
  logic restarted_r;
  logic irq_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Wake recognition.

  // Inside a handler only a strictly higher priority (lower number) counts.
  always_comb
  begin
    irq_ok = 1'b0;
    for (int i = 0; i < IRQS; i++)
    begin
      if (irq_pend[i] && (!in_handler || (irq_prio[i*PRIO_W +: PRIO_W] < cur_prio)))
        irq_ok = 1'b1;
    end
  end

  wire in_sleep = state_r == PMS_CS_SLEEP;
  assign link.wake_recognized = in_sleep & (irq_ok | (is_wfe_r & event_r));

  //////////////////////////////////////////////////////////////////////////////
  // Wait issue.

  // Barriers: the wait leaves only after bus accesses drain; deep waits also
  // need DMA idle and, when fast wake is wanted, low-power oscillator clocks.
  wire drained = ~bus_busy & (~deep_r | (~dma_active & (~fast_wake_want | low_power_oscillator_clocking)));
  wire wait_cmd = wfi_req | wfe_req;
  assign link.wait_req = (state_r == PMS_CS_DRAIN) & drained;
  assign link.deep_sleep_flag = deep_r;

  // A pending event lets a wait-for-event fall straight through.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PMS_CS_EXEC:
      begin
        if (wfe_req && event_r)
          state_nxt = PMS_CS_EXEC;
        else if (wait_cmd)
          state_nxt = PMS_CS_DRAIN;
      end
      PMS_CS_DRAIN:
      begin
        if (drained)
          state_nxt = PMS_CS_SLEEP;
      end
      PMS_CS_SLEEP:
      begin
        if (link.core_reset)
          state_nxt = PMS_CS_EXEC;
        else if (link.resume)
          state_nxt = PMS_CS_EXEC;
        else if (!link.core_clk_en && deep_r)
          state_nxt = PMS_CS_SLEEP;
      end
      PMS_CS_POWOFF:
      begin
        state_nxt = PMS_CS_EXEC;
      end
      default:
      begin
        state_nxt = PMS_CS_EXEC;
      end
    endcase
  end

  // Core end registers; an event arriving as one is consumed is kept.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= PMS_CS_EXEC;
      is_wfe_r <= 1'b0;
      event_r <= 1'b0;
      deep_r <= 1'b0;
      resumed_r <= 1'b0;
      restarted_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == PMS_CS_EXEC && wait_cmd)
        is_wfe_r <= wfe_req;
      if (event_in)
        event_r <= 1'b1;
      else if ((wfe_req && state_r == PMS_CS_EXEC) || (in_sleep && link.resume && is_wfe_r))
        event_r <= 1'b0;
      deep_r <= deep_sleep_set;
      resumed_r <= in_sleep & link.resume;
      restarted_r <= link.core_reset;
    end
  end

  assign core_running = (state_r == PMS_CS_EXEC) & link.core_clk_en;
  assign resumed = resumed_r;
  assign restarted = restarted_r;

endmodule

// *** verif/pms_link_checker.sv ***
// Checker for the core link of the power mode sequencer.
// Assumes the link signals and the shared clock come in as plain inputs.
`timescale 1ns/1ps
module pms_link_checker
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Link signals.
  input wire logic wait_req,
  input wire logic deep_sleep_flag,
  input wire logic wake_recognized,
  input wire logic core_clk_en,
  input wire logic resume,
  input wire logic core_reset
);
  ////////////////////////////////////////
  // All checks share one clock and stay quiet while reset is held.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_WAIT_STOPS_CORE: assert property (wait_req |=> !core_clk_en)
    else $error("core clock still on after wait");
  AST_ONE_WAIT: assert property (wait_req |=> !wait_req [*3])
    else $error("wait request repeated while asleep");
  // Halt wake must land exactly four clocks after recognition, never sooner.
  AST_HALT_WAKE_TIME: assert property ($rose(wake_recognized) && !deep_sleep_flag |-> !resume [*4] ##1 resume)
    else $error("halt wake time wrong");
  AST_DEEP_SLOWER: assert property ($fell(core_clk_en) && deep_sleep_flag |-> !resume [*8])
    else $error("deep sleep resumed too early");
  AST_RESUME_PULSE: assert property (resume |=> !resume)
    else $error("resume longer than one cycle");
  AST_RESUME_CLOCK: assert property (resume |-> core_clk_en && !$past(core_clk_en))
    else $error("resume without clock restart");
  AST_CLOCK_RESTART: assert property ($rose(core_clk_en) |-> resume || $past(core_reset))
    else $error("core clock restarted without cause");
  AST_RESET_EXIT: assert property (core_reset |=> !core_reset && core_clk_en)
    else $error("retention exit malformed");
endmodule

// *** verif/tb_top.sv ***
// Testbench joining the core end and the sequencer over their link.
// Assumes the core files and the link checker are compiled first.
`timescale 1ns/1ps
module tb_top
  import pms_pkg::*;
;
  logic clock = 0;
  logic reset = 1;
  logic run_from_ram = 1, slow_clock_sel = 0, deep_mode_select = 0, fast_wake_en = 0, fast_wake_src = 0;
  logic charge_pump_sel = 0, wfi_req = 0, wfe_req = 0, deep_sleep_set = 0, fast_wake_want = 0;
  logic low_power_oscillator_clocking = 0, bus_busy = 0, dma_active = 0, in_handler = 0, event_in = 0;
  logic [7:0] stop_wake_mask = 8'h0F, stop_wake_src = 8'h00, irq_pend = 8'h00;
  logic [3:0] ram_retain_sel = 4'h0;
  logic [8:0] ret_wake_mask = 9'h1FF, ret_wake_src = 9'h000;
  logic [6:0] ret_reset_mask = 7'h3F, ret_reset_src = 7'h00;
  logic [23:0] irq_prio = {{4{3'h1}}, {4{3'h5}}};
  logic [2:0] cur_prio = 3'h3;
  logic periph_clk_en, clk_slow, lf_osc_keep, rtc_clk_keep, core_pwr_en, periph_pwr_en, regulator_en;
  logic charge_pump_en, lp_domain_en, sys_reset_req, core_running, resumed, restarted;
  logic [3:0] ram_pwr_en;
  pms_mode_t power_mode;
  int errors = 0;
  int checks_done = 0;
  int n;
  logic [1:0] exp_q[$];

  always #5 clock = ~clock;

  pms_link_if pms_link_if_inst();
  pms_sequencer #(.STOP_WAKES(8), .RAM_BLOCKS(4)) pms_sequencer_inst (.clock, .reset, .link(pms_link_if_inst),
    .run_from_ram, .slow_clock_sel, .deep_mode_select, .fast_wake_en, .fast_wake_src, .stop_wake_mask,
    .stop_wake_src, .charge_pump_sel, .ram_retain_sel, .ret_wake_mask, .ret_wake_src, .ret_reset_mask,
    .ret_reset_src, .periph_clk_en, .clk_slow, .lf_osc_keep, .rtc_clk_keep, .core_pwr_en, .periph_pwr_en,
    .regulator_en, .charge_pump_en, .ram_pwr_en, .lp_domain_en, .power_mode, .sys_reset_req);
  pms_core_end #(.IRQS(8), .PRIO_W(3)) pms_core_end_inst (.clock, .reset, .link(pms_link_if_inst), .wfi_req,
    .wfe_req, .deep_sleep_set, .fast_wake_want, .low_power_oscillator_clocking, .bus_busy, .dma_active, .irq_pend, .irq_prio,
    .in_handler, .cur_prio, .event_in, .core_running, .resumed, .restarted);
  pms_link_checker pms_link_checker_inst (.clock, .reset, .wait_req(pms_link_if_inst.wait_req),
    .deep_sleep_flag(pms_link_if_inst.deep_sleep_flag), .wake_recognized(pms_link_if_inst.wake_recognized),
    .core_clk_en(pms_link_if_inst.core_clk_en), .resume(pms_link_if_inst.resume),
    .core_reset(pms_link_if_inst.core_reset));

  ////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Pulse a wait instruction, then let the core settle asleep.
  task issue_wait(input logic use_wfe);
    @(posedge clock) {wfe_req, wfi_req} <= use_wfe ? 2'h2 : 2'h1;
    @(posedge clock) {wfe_req, wfi_req} <= 2'h0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // Bounded wait for the monitor to consume every pending note.
  task drain;
    n = 0;
    while (exp_q.size() != 0 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    check(8'(exp_q.size()), 8'h00);
  endtask

  // Each resume or restart pulse is matched against the oldest note.
  always @(posedge clock)
    if (!reset && (resumed === 1'b1 || restarted === 1'b1))
      check({resumed, restarted}, exp_q.size() ? exp_q.pop_front() : 2'h0);

  ////////////////////////////////////////
  initial
  begin
    void'($urandom(94));
    repeat (10) @(posedge clock);
    reset <= 0;
    // Running from flash is reported apart from the two RAM run modes.
    @(posedge clock) run_from_ram <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(power_mode, PMS_MODE_FLASH_RUN);
    @(posedge clock) run_from_ram <= 1'b1;
    // Core halt at both speeds; a low-priority irq inside a handler must not wake.
    // A busy bus holds the wait back, so halt is entered only once it drains.
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock) slow_clock_sel <= i[0];
      in_handler <= !i[0];
      bus_busy <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      check(power_mode, i ? PMS_MODE_RAM_RUN_SLOW : PMS_MODE_RAM_RUN);
      issue_wait(i[0]);
      check(power_mode, i ? PMS_MODE_RAM_RUN_SLOW : PMS_MODE_RAM_RUN);
      @(posedge clock) bus_busy <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check(power_mode, i ? PMS_MODE_CORE_HALT_SLOW : PMS_MODE_CORE_HALT);
      check({periph_clk_en, clk_slow, core_running}, {1'b1, i[0], 1'b0});
      if (i == 0)
      begin
        @(posedge clock) irq_pend <= 8'h01 << ($urandom % 4);
        repeat (10) @(posedge clock);
        #1;
        check(core_running, 1'b0);
      end
      exp_q.push_back(2'h2);
      @(posedge clock)
        if (i == 0)
          irq_pend <= 8'h10 << ($urandom % 4);
        else
          event_in <= 1;
      @(posedge clock) event_in <= 0;
      drain;
      @(posedge clock) irq_pend <= 8'h00;
      in_handler <= 0;
    end
    // Clock stop, slow then fast wake; masked sources are refused.
    @(posedge clock) deep_sleep_set <= 1;
    for (int f = 0; f < 2; f++)
    begin
      // Active DMA, and for fast wake a core not on the low-power oscillator, hold the deep wait back.
      @(posedge clock) fast_wake_en <= f[0];
      fast_wake_src <= 1'($urandom);
      fast_wake_want <= f[0];
      low_power_oscillator_clocking <= 1'b0;
      dma_active <= 1'b1;
      stop_wake_mask <= 8'h01 << ($urandom % 8);
      issue_wait(1'b0);
      check(power_mode, PMS_MODE_RAM_RUN_SLOW);
      @(posedge clock) dma_active <= 1'b0;
      low_power_oscillator_clocking <= !f[0];
      repeat (3) @(posedge clock);
      #1;
      check(power_mode, f ? PMS_MODE_RAM_RUN_SLOW : PMS_MODE_CLOCK_STOP);
      @(posedge clock) low_power_oscillator_clocking <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      check(power_mode, PMS_MODE_CLOCK_STOP);
      check({periph_clk_en, lf_osc_keep, rtc_clk_keep}, {1'b0, f[0] & ~fast_wake_src, f[0] & fast_wake_src});
      @(posedge clock) stop_wake_src <= ~stop_wake_mask;
      repeat (70) @(posedge clock);
      #1;
      check(power_mode, PMS_MODE_CLOCK_STOP);
      exp_q.push_back(2'h2);
      @(posedge clock) stop_wake_src <= stop_wake_mask;
      n = 0;
      while (pms_link_if_inst.resume !== 1'b1 && n < 100)
      begin
        @(posedge clock);
        #1;
        n++;
      end
      check(n[7:0], f ? 8'h10 : 8'h40);
      drain;
      @(posedge clock) stop_wake_src <= 8'h00;
    end
    // Retention, left once through each reset source; a plain wake is refused.
    @(posedge clock) deep_mode_select <= 1;
    charge_pump_sel <= 1;
    ram_retain_sel <= 4'($urandom);
    for (int k = 0; k < 7; k++)
    begin
      issue_wait(k[0]);
      check(power_mode, PMS_MODE_RETENTION);
      check({core_pwr_en, periph_pwr_en, regulator_en, charge_pump_en, lp_domain_en}, 8'h03);
      check(ram_pwr_en, ram_retain_sel);
      @(posedge clock) ret_wake_src <= 9'h001 << ($urandom % 9);
      repeat (20) @(posedge clock);
      #1;
      check(power_mode, PMS_MODE_RETENTION);
      exp_q.push_back(2'h1);
      @(posedge clock)
        if (k < 6)
          ret_reset_src[k] <= 1;
        else
          ret_reset_mask <= 7'h7F;
      // The system reset request pulses one clock after the allowed source appears.
      @(posedge clock);
      #1;
      check(sys_reset_req, 1'b1);
      drain;
      @(posedge clock) ret_reset_src <= 7'h00;
      ret_wake_src <= 9'h000;
      ret_reset_mask <= 7'h3F;
    end
    stop_test;
  end

  // A hang counts as a mismatch and ends the run the normal way.
  initial
  begin
    repeat (5000) @(posedge clock);
    errors++;
    stop_test;
  end
endmodule
